/* rtl/pwm_carrier_timer8_pkg.sv */
// shared constants and types for the pwm and carrier compare timer
// Operation
// R1 - after run enable, one count clock is skipped; output stays inactive meanwhile
// R2 - duty writes while running are latched, applied at the old duty match
// R3 - latched duty needs three count clocks before a match may transfer it
// R4 - pwm period match clears counter, drives output active, pulses interrupt
// R5 - pwm duty match drives output inactive, no clear, no interrupt
// R6 - clearing run enable forces interrupt and output inactive at once
// R7 - carrier mode only on instance 1; low and high width compares
// R8 - software may rewrite high width but not low width while counting
// R9 - pin follows remote enable and carrier enable per the four-way table
// R10 - slave enable is read-only, master read/write, only slave gates output
// R11 - gate interrupt synced to count clock; slave loads master two clocks later
// R12 - software waits two count clocks between writes of the master bit
// R13 - carrier compares low width first; each match clears, inverts, swaps
// R14 - carrier period is N+M+2 count clocks, high time M+1
// R15 - slave and remote enable set drive the carrier onto the pin
// R16 - carrier clock held inactive from start until first low width match
// R17 - enable starts output at next rising edge; disable keeps full high phase
// R18 - software rewrites high width compare on every restart
// R19 - count clock must be over six times the gate counter clock
// R20 - low and high width compares programmed between 01H and FFH
// R21 - software sets remote enable before starting carrier counting
// R22 - pwm duty compare kept strictly below period compare
// R23 - each compare match interrupt is one count clock wide
package pwm_carrier_timer8_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CKS_W = 3;
  localparam int DIV_W = 7;
  // register offsets
  localparam logic [2:0] MODE_OFS = 3'h0;
  localparam logic [2:0] PERIOD_OFS = 3'h1;
  localparam logic [2:0] DUTY_OFS = 3'h2;
  localparam logic [2:0] CTRL_OFS = 3'h3;
  localparam logic [2:0] STATUS_OFS = 3'h4;
  // mode register fields
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_CARRIER_BIT = 1;
  localparam int MODE_LEVEL_BIT = 2;
  localparam int MODE_CKS_LSB = 4;
  // carrier control register fields
  localparam int CTRL_SLAVE_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_REMOTE_BIT = 2;
  // status register fields
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_SEL_BIT = 1;
  localparam int STAT_CCLK_BIT = 2;
  // reset values
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [2:0] CKS_RESET = 3'h0;
  // count clocks a latched duty value must age before transfer
  localparam logic [1:0] XFER_MIN_TICKS = 2'h3;
  typedef enum logic {CMP_FIRST, CMP_SECOND} cmp_sel_e;
endpackage : pwm_carrier_timer8_pkg

/* rtl/tick_divider.sv */
// count clock enable generator from the system clock
`timescale 1ns/10ps
module tick_divider #(
  parameter int DIV_W = pwm_carrier_timer8_pkg::DIV_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [pwm_carrier_timer8_pkg::CKS_W-1:0] count_clock_select,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } div_state_s;

  div_state_s s_q;
  div_state_s s_d;
  logic [DIV_W-1:0] mask;

  // one tick every 2^select system clocks
  always_comb begin
    s_d = s_q;
    mask = DIV_W'(({{DIV_W{1'b0}}, 1'b1} << count_clock_select) - 1'b1);
    s_d.cnt = DIV_W'(s_q.cnt + 1'b1);
    s_d.tick = ((s_q.cnt & mask) == mask);
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : tick_divider

/* rtl/pwm_carrier_timer8.sv */
// 8-bit compare timer with pwm output and carrier generator modes
`timescale 1ns/10ps
module pwm_carrier_timer8 #(
  parameter bit CARRIER_CAPABLE = 1'b1,
  parameter int DIV_W = pwm_carrier_timer8_pkg::DIV_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [pwm_carrier_timer8_pkg::ADDR_W-1:0] addr,
  input wire logic [pwm_carrier_timer8_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [pwm_carrier_timer8_pkg::DATA_W-1:0] rd_data,
  input wire logic gate_counter_irq,
  output logic compare_match_irq,
  output logic timer_output_pin
);
  typedef struct packed {
    logic timer_run_enable;
    logic carrier_mode;
    logic output_level_select;
    logic [pwm_carrier_timer8_pkg::CKS_W-1:0] count_clock_select;
    logic [7:0] period_compare;
    logic [7:0] duty_compare;
    logic [7:0] duty_latch;
    logic duty_pending;
    logic [1:0] latch_age;
    logic carrier_enable_master;
    logic carrier_enable_slave;
    logic remote_output_enable;
    logic gate_meta;
    logic gate_sync;
    logic gate_prev;
    logic synced_gate_pulse;
    logic gate_xfer;
    logic [7:0] cnt;
    logic skip;
    pwm_carrier_timer8_pkg::cmp_sel_e sel;
    logic active;
    logic carrier_clk;
    logic carrier_gate;
    logic irq;
    logic pin;
    logic [7:0] rdata;
  } timer_state_s;

  timer_state_s s_q;
  timer_state_s s_d;
  logic tick;
  logic run_next;
  logic match;
  logic duty_ready;
  logic [7:0] cmp_val;

  // count clock enable
  tick_divider #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .count_clock_select(s_q.count_clock_select),
    .tick(tick)
  );

  // run state as it stands after this cycle's write
  assign run_next = (wr_en && addr == pwm_carrier_timer8_pkg::MODE_OFS) ?
                    wr_data[pwm_carrier_timer8_pkg::MODE_RUN_BIT] : s_q.timer_run_enable;
  assign cmp_val = (s_q.sel == pwm_carrier_timer8_pkg::CMP_FIRST) ?
                   s_q.period_compare : s_q.duty_compare;
  assign match = tick && s_q.timer_run_enable && !s_q.skip && (s_q.cnt == cmp_val);
  assign duty_ready = s_q.duty_pending && (s_q.latch_age == pwm_carrier_timer8_pkg::XFER_MIN_TICKS);

  // next state of the whole timer
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    // gate interrupt crosses from outside through two flops
    s_d.gate_meta = gate_counter_irq;
    s_d.gate_sync = s_q.gate_meta;
    if (tick) begin
      // resample on the count clock, rising edge gives the gate pulse
      s_d.gate_prev = s_q.gate_sync;
      s_d.synced_gate_pulse = s_q.gate_sync && !s_q.gate_prev; // R11
      s_d.gate_xfer = s_q.synced_gate_pulse;
      if (s_q.gate_xfer) begin
        s_d.carrier_enable_slave = s_q.carrier_enable_master; // R11 R10
      end
      if (s_q.duty_pending && !duty_ready) begin
        s_d.latch_age = 2'(s_q.latch_age + 1'b1); // R3
      end
    end
    // counting on each count clock
    if (tick && s_q.timer_run_enable) begin
      s_d.irq = 1'b0; // R23
      if (s_q.skip) begin
        s_d.skip = 1'b0; // R1
      end else if (match && s_q.carrier_mode) begin
        // alternate low and high width, each phase lasts compare plus one
        s_d.cnt = 8'h00; // R13 R14
        s_d.irq = 1'b1; // R13
        s_d.carrier_clk = !s_q.carrier_clk; // R13
        unique case (s_q.sel)
          pwm_carrier_timer8_pkg::CMP_FIRST: begin
            s_d.sel = pwm_carrier_timer8_pkg::CMP_SECOND; // R13
          end
          pwm_carrier_timer8_pkg::CMP_SECOND: begin
            s_d.sel = pwm_carrier_timer8_pkg::CMP_FIRST; // R13
            if (duty_ready) begin
              s_d.duty_compare = s_q.duty_latch; // R2
              s_d.duty_pending = 1'b0;
            end
          end
        endcase
      end else if (match) begin
        unique case (s_q.sel)
          pwm_carrier_timer8_pkg::CMP_FIRST: begin
            s_d.cnt = 8'h00; // R4
            s_d.irq = 1'b1; // R4
            s_d.active = 1'b1; // R4
            s_d.sel = pwm_carrier_timer8_pkg::CMP_SECOND;
          end
          pwm_carrier_timer8_pkg::CMP_SECOND: begin
            s_d.cnt = 8'(s_q.cnt + 1'b1); // R5
            s_d.active = 1'b0; // R5
            s_d.sel = pwm_carrier_timer8_pkg::CMP_FIRST;
            if (duty_ready) begin
              s_d.duty_compare = s_q.duty_latch; // R2 R3
              s_d.duty_pending = 1'b0;
            end
          end
        endcase
      end else begin
        s_d.cnt = 8'(s_q.cnt + 1'b1);
      end
    end
    // stopped timer: counter, compare select, pwm output, irq and carrier clock idle, next start skips one count clock
    if (!run_next) begin
      s_d.cnt = 8'h00;
      s_d.skip = 1'b1; // R1
      s_d.sel = pwm_carrier_timer8_pkg::CMP_FIRST; // R13
      s_d.active = 1'b0; // R6
      s_d.irq = 1'b0; // R6
      s_d.carrier_clk = 1'b0; // R16
      s_d.duty_pending = 1'b0;
    end
    // register writes, a duty write in a transfer cycle is latched and left pending while the transfer still completes
    if (wr_en) begin
      unique case (addr)
        pwm_carrier_timer8_pkg::MODE_OFS: begin
          s_d.timer_run_enable = wr_data[pwm_carrier_timer8_pkg::MODE_RUN_BIT];
          s_d.carrier_mode = CARRIER_CAPABLE &&
                             wr_data[pwm_carrier_timer8_pkg::MODE_CARRIER_BIT]; // R7
          s_d.output_level_select = wr_data[pwm_carrier_timer8_pkg::MODE_LEVEL_BIT];
          s_d.count_clock_select =
            wr_data[pwm_carrier_timer8_pkg::MODE_CKS_LSB +: pwm_carrier_timer8_pkg::CKS_W];
        end
        pwm_carrier_timer8_pkg::PERIOD_OFS: begin
          s_d.period_compare = wr_data; // R7
        end
        pwm_carrier_timer8_pkg::DUTY_OFS: begin
          if (s_q.timer_run_enable) begin
            s_d.duty_latch = wr_data; // R2
            s_d.duty_pending = 1'b1; // R2
            s_d.latch_age = 2'h0; // R3
          end else begin
            s_d.duty_compare = wr_data;
            s_d.duty_pending = 1'b0;
          end
        end
        pwm_carrier_timer8_pkg::CTRL_OFS: begin
          s_d.carrier_enable_master = wr_data[pwm_carrier_timer8_pkg::CTRL_MASTER_BIT]; // R10
          s_d.remote_output_enable = wr_data[pwm_carrier_timer8_pkg::CTRL_REMOTE_BIT];
        end
        default: begin
        end
      endcase
    end
    // read data, valid in the cycle after the strobe only
    if (rd_en) begin
      unique case (addr)
        pwm_carrier_timer8_pkg::MODE_OFS: begin
          s_d.rdata[pwm_carrier_timer8_pkg::MODE_RUN_BIT] = s_q.timer_run_enable;
          s_d.rdata[pwm_carrier_timer8_pkg::MODE_CARRIER_BIT] = s_q.carrier_mode;
          s_d.rdata[pwm_carrier_timer8_pkg::MODE_LEVEL_BIT] = s_q.output_level_select;
          s_d.rdata[pwm_carrier_timer8_pkg::MODE_CKS_LSB +: pwm_carrier_timer8_pkg::CKS_W] =
            s_q.count_clock_select;
        end
        pwm_carrier_timer8_pkg::PERIOD_OFS: begin
          s_d.rdata = s_q.period_compare;
        end
        pwm_carrier_timer8_pkg::DUTY_OFS: begin
          s_d.rdata = s_q.duty_compare;
        end
        pwm_carrier_timer8_pkg::CTRL_OFS: begin
          s_d.rdata[pwm_carrier_timer8_pkg::CTRL_SLAVE_BIT] = s_q.carrier_enable_slave;
          s_d.rdata[pwm_carrier_timer8_pkg::CTRL_MASTER_BIT] = s_q.carrier_enable_master;
          s_d.rdata[pwm_carrier_timer8_pkg::CTRL_REMOTE_BIT] = s_q.remote_output_enable;
        end
        pwm_carrier_timer8_pkg::STATUS_OFS: begin
          s_d.rdata[pwm_carrier_timer8_pkg::STAT_PEND_BIT] = s_q.duty_pending;
          s_d.rdata[pwm_carrier_timer8_pkg::STAT_SEL_BIT] =
            (s_q.sel == pwm_carrier_timer8_pkg::CMP_SECOND);
          s_d.rdata[pwm_carrier_timer8_pkg::STAT_CCLK_BIT] = s_q.carrier_clk;
        end
        default: begin
        end
      endcase
    end
    // output gate only moves while the carrier is low or just rising
    if (!s_d.carrier_clk || !s_q.carrier_clk) begin
      s_d.carrier_gate = s_d.carrier_enable_slave; // R17
    end
    // pin drive
    if (s_d.carrier_mode) begin
      s_d.pin = s_d.remote_output_enable ?
                (s_d.carrier_clk && s_d.carrier_gate) : s_d.carrier_enable_slave; // R9 R15
    end else begin
      s_d.pin = s_d.active ^ s_d.output_level_select; // R1 R4 R5
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.period_compare <= pwm_carrier_timer8_pkg::CMP_RESET;
      s_q.duty_compare <= pwm_carrier_timer8_pkg::CMP_RESET;
      s_q.count_clock_select <= pwm_carrier_timer8_pkg::CKS_RESET;
      s_q.skip <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rdata;
  assign compare_match_irq = s_q.irq;
  assign timer_output_pin = s_q.pin;

  // checks on the timer behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_stop_irq_low: assert property ( // R6
    ce && !run_next |=> !compare_match_irq) else $error("irq active after stop");
  a_stop_out_idle: assert property ( // R6
    ce && !run_next && !s_d.carrier_mode |=> timer_output_pin == s_q.output_level_select)
    else $error("pwm output not idle after stop");
  a_start_skip: assert property ( // R1
    ce && tick && run_next && s_q.timer_run_enable && s_q.skip |=> s_q.cnt == 8'h00 && !s_q.skip)
    else $error("first count clock not skipped");
  a_period_match: assert property ( // R4
    ce && run_next && match && !s_q.carrier_mode && s_q.sel == pwm_carrier_timer8_pkg::CMP_FIRST
    |=> s_q.cnt == 8'h00 && compare_match_irq &&
        timer_output_pin == !s_q.output_level_select)
    else $error("period match misbehaves");
  a_duty_match: assert property ( // R5
    ce && run_next && match && !s_q.carrier_mode && s_q.sel == pwm_carrier_timer8_pkg::CMP_SECOND
    |=> !compare_match_irq && s_q.cnt == 8'($past(s_q.cnt) + 1'b1) &&
        timer_output_pin == s_q.output_level_select)
    else $error("duty match misbehaves");
  a_duty_xfer: assert property ( // R2
    ce && run_next && match && duty_ready && s_q.sel == pwm_carrier_timer8_pkg::CMP_SECOND &&
    !(wr_en && addr == pwm_carrier_timer8_pkg::DUTY_OFS)
    |=> s_q.duty_compare == $past(s_q.duty_latch) && !s_q.duty_pending)
    else $error("latched duty not transferred");
  a_early_hold: assert property ( // R3
    ce && s_q.duty_pending && !duty_ready &&
    !(wr_en && addr == pwm_carrier_timer8_pkg::DUTY_OFS)
    |=> s_q.duty_compare == $past(s_q.duty_compare))
    else $error("duty transferred too early");
  a_slave_xfer: assert property ( // R11
    ce && tick && s_q.gate_xfer |=> s_q.carrier_enable_slave == $past(s_q.carrier_enable_master))
    else $error("slave not loaded from master");
  a_slave_ro: assert property ( // R10
    ce && !(tick && s_q.gate_xfer) |=> $stable(s_q.carrier_enable_slave))
    else $error("slave bit changed without gate pulse");
  a_carrier_swap: assert property ( // R13
    ce && run_next && match && s_q.carrier_mode
    |=> s_q.cnt == 8'h00 && compare_match_irq && s_q.carrier_clk != $past(s_q.carrier_clk) &&
        s_q.sel != $past(s_q.sel))
    else $error("carrier match misbehaves");
  a_carrier_idle: assert property ( // R16
    ce && !run_next |=> !s_q.carrier_clk) else $error("carrier active while stopped");
  a_pin_table: assert property ( // R9
    ce && s_d.carrier_mode && !s_d.remote_output_enable
    |=> timer_output_pin == s_q.carrier_enable_slave)
    else $error("pin disagrees with enable table");
  a_high_kept: assert property ( // R17
    ce && s_q.carrier_mode && s_q.remote_output_enable && s_q.carrier_clk && s_q.carrier_gate &&
    !match && run_next && !wr_en |=> timer_output_pin) else $error("carrier high phase cut");
  a_irq_pulse: assert property ( // R23
    ce && tick && s_q.irq && !match |=> !compare_match_irq) else $error("irq wider than a tick");
  a_carrier_only: assert property ( // R7
    CARRIER_CAPABLE || !s_q.carrier_mode) else $error("carrier mode on plain instance");

  c_pwm_cycle: cover property (match && !s_q.carrier_mode &&
                               s_q.sel == pwm_carrier_timer8_pkg::CMP_SECOND);
  c_duty_xfer: cover property (match && duty_ready);
  c_slave_on: cover property (tick && s_q.gate_xfer && s_q.carrier_enable_master);
  c_carrier_out: cover property (s_q.carrier_mode && s_q.pin && s_q.remote_output_enable);
endmodule : pwm_carrier_timer8

/* tb/gate_counter_model.sv */
// behavioural model of the slower gate counter that raises the gate interrupt
`timescale 1ns/10ps
module gate_counter_model #(
  parameter int HOLD = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic fire,
  output logic gate_counter_irq
);
  logic [3:0] hold_q;
  // interrupt lasts one slow count clock, longer than six timer ticks
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hold_q <= 4'h0;
    end else if (fire) begin
      hold_q <= 4'(HOLD);
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
  // level irq while the slow count clock period runs
  assign gate_counter_irq = (hold_q != 4'h0);
endmodule : gate_counter_model

/* tb/pwm_carrier_timer8_test.sv */
// self-checking bench for the pwm and carrier compare timer
`timescale 1ns/10ps
module pwm_carrier_timer8_test;
  localparam logic [2:0] MODE = pwm_carrier_timer8_pkg::MODE_OFS;
  localparam logic [2:0] PER = pwm_carrier_timer8_pkg::PERIOD_OFS;
  localparam logic [2:0] DUTY = pwm_carrier_timer8_pkg::DUTY_OFS;
  localparam logic [2:0] CTRL = pwm_carrier_timer8_pkg::CTRL_OFS;
  logic clk_sys, rst_b, ce, wr_en, rd_en, fire, rise;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, rv;
  logic gate_counter_irq, compare_match_irq, timer_output_pin;
  logic pin_prev = 1'b0, irq_prev = 1'b0;
  int fail_count = 0, num_checks = 0, cyc = 0, hi_cnt = 0, last_hi = 0, last_per = 0;
  int rise_cyc = 0, runs = 0, rises = 0, irq_mode = 0;

  pwm_carrier_timer8 u_pwm_carrier_timer8 (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .gate_counter_irq(gate_counter_irq), .compare_match_irq(compare_match_irq),
    .timer_output_pin(timer_output_pin));
  gate_counter_model u_gate_counter_model (.clk_sys(clk_sys), .rst_b(rst_b), .fire(fire),
    .gate_counter_irq(gate_counter_irq));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd

  // pin and irq monitor: widths of high runs, rise-to-rise spacing
  always @(posedge clk_sys) begin
    #1;
    cyc++;
    rise = (timer_output_pin === 1'b1 && pin_prev !== 1'b1);
    if (rise) begin
      rises++;
      hi_cnt = 1;
      last_per = cyc - rise_cyc;
      rise_cyc = cyc;
    end else if (timer_output_pin === 1'b1) begin
      hi_cnt++;
    end
    if (timer_output_pin !== 1'b1 && pin_prev === 1'b1) begin
      last_hi = hi_cnt;
      runs++;
    end
    if (irq_prev === 1'b1 && irq_mode != 3) chk("irq_width", compare_match_irq, 1'b0);
    if (irq_mode == 1) chk("irq_at_period", compare_match_irq, rise);
    if (irq_mode == 2) chk("irq_at_edge", compare_match_irq, timer_output_pin ^ pin_prev);
    pin_prev = timer_output_pin;
    irq_prev = compare_match_irq;
  end

  task automatic wait_run(input int hi, input int per);
    int r, n;
    r = runs;
    n = 0;
    while (runs == r && n < 600) begin
      @(posedge clk_sys);
      #2 n++;
    end
    chk("run_seen", 16'(runs - r), 16'h0001);
    if (hi > 0) chk("high_width", 16'(last_hi), 16'(hi));
    if (per > 0) chk("period", 16'(last_per), 16'(per));
  endtask : wait_run

  task automatic wait_rise();
    int r, n;
    r = rises;
    n = 0;
    while (rises == r && n < 600) begin
      @(posedge clk_sys);
      #2 n++;
    end
    chk("rise_seen", 16'(rises - r), 16'h0001);
  endtask : wait_rise

  // one gate interrupt, then poll the slave bit
  task automatic gate(input logic exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    do begin
      rd(CTRL);
      n++;
    end while (rv[0] !== exp && n < 20);
    chk("slave_bit", rv[0], exp);
  endtask : gate

  task automatic t_regs();
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk("reset_value", rv, 8'h00);
    end
    wr(3'h5, 8'hFF);
    wr(3'h4, 8'hFF);
    rd(3'h5);
    chk("unmapped", rv, 8'h00);
    rd(3'h4);
    chk("status_ro", rv, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_pwm();
    wr(PER, 8'h09);
    wr(DUTY, 8'h03);
    wr(MODE, 8'h01);
    @(posedge clk_sys);
    #1 chk("pin_start", timer_output_pin, 1'b0);
    irq_mode = 1;
    wait_run(4, 0);
    wait_run(4, 10);
    wr(DUTY, 8'h06);
    rd(DUTY);
    chk("duty_latched", rv, 8'h03);
    wait_run(0, 0);
    wait_run(0, 0);
    wait_run(7, 10);
    // write lands one tick before the old match, so no transfer there
    wait_rise();
    repeat (4) @(posedge clk_sys);
    wr(DUTY, 8'h02);
    wait_run(7, 10);
    wait_run(7, 10);
    wait_run(3, 10);
    wait_rise();
    irq_mode = 0;
    wr(MODE, 8'h00);
    #1 chk("pin_stop", timer_output_pin, 1'b0);
    chk("irq_stop", compare_match_irq, 1'b0);
    $display("test pwm done");
  endtask : t_pwm

  // count clock at a quarter of the system clock, stop in mid pulse
  task automatic t_slow();
    wr(PER, 8'h04);
    wr(DUTY, 8'h01);
    irq_mode = 3;
    wr(MODE, 8'h21);
    wait_run(8, 0);
    wait_run(8, 20);
    wait_rise();
    wr(MODE, 8'h20);
    #1 chk("irq_stop_slow", compare_match_irq, 1'b0);
    chk("pin_stop_slow", timer_output_pin, 1'b0);
    irq_mode = 0;
    $display("test slow done");
  endtask : t_slow

  task automatic t_carrier();
    wr(PER, 8'h04);
    wr(DUTY, 8'h02);
    wr(CTRL, 8'h06);
    rd(CTRL);
    chk("ctrl_master_only", rv, 8'h06);
    wr(MODE, 8'h03);
    repeat (20) begin
      @(posedge clk_sys);
      #1 chk("pin_gated_off", timer_output_pin, 1'b0);
    end
    gate(1'b1);
    wait_run(3, 0);
    irq_mode = 2;
    wait_run(3, 8);
    wait_run(3, 8);
    // high width rewritten while counting, taken at the old high match
    wr(DUTY, 8'h03);
    wait_run(3, 8);
    wait_run(4, 8);
    irq_mode = 0;
    wr(CTRL, 8'h04);
    // slave drops one clock into a high phase, which must stay whole
    wait_rise();
    repeat (3) @(posedge clk_sys);
    gate(1'b0);
    repeat (24) @(posedge clk_sys);
    #1 chk("last_high_kept", 16'(last_hi), 16'h0004);
    chk("pin_remote_off", timer_output_pin, 1'b0);
    wr(CTRL, 8'h02);
    gate(1'b1);
    repeat (8) begin
      @(posedge clk_sys);
      #1 chk("pin_level_high", timer_output_pin, 1'b1);
    end
    wr(CTRL, 8'h00);
    rd(CTRL);
    chk("slave_ro", rv, 8'h01);
    chk("slave_gates", timer_output_pin, 1'b1);
    gate(1'b0);
    chk("pin_level_low", timer_output_pin, 1'b0);
    wr(MODE, 8'h00);
    $display("test carrier done");
  endtask : t_carrier

  // watchdog against a hung handshake or counter
  initial begin
    #160000;
    fail_count++;
    $display("unexpected watchdog expected done seen timeout");
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fire = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_pwm();
    t_slow();
    t_carrier();
    end_sim();
  end
endmodule : pwm_carrier_timer8_test
